/* File: vgd_pkg.sv */
package vgd_pkg;

  // Register indices behind the data port
  localparam logic [3:0] IDX_SET_RESET   = 4'h0;
  localparam logic [3:0] IDX_SR_ENABLE   = 4'h1;
  localparam logic [3:0] IDX_COMPARE     = 4'h2;
  localparam logic [3:0] IDX_ROTATE_FUNC = 4'h3;
  localparam logic [3:0] IDX_READ_PLANE  = 4'h4;
  localparam logic [3:0] IDX_MODE_CTRL   = 4'h5;
  localparam logic [3:0] IDX_MISC        = 4'h6;
  localparam logic [3:0] IDX_DONT_CARE   = 4'h7;
  localparam logic [3:0] IDX_BIT_MASK    = 4'h8;
  localparam int         NUM_REGS        = 9;

  // Implemented bits of each register; the rest read as zero
  localparam logic [7:0] MASK_INDEX      = 8'h0F;
  localparam logic [7:0] MASK_NIBBLE     = 8'h0F;
  localparam logic [7:0] MASK_ROTATE     = 8'h1F;
  localparam logic [7:0] MASK_READ_PLANE = 8'h03;
  localparam logic [7:0] MASK_MODE_CTRL  = 8'h7B;
  localparam logic [7:0] MASK_FULL       = 8'hFF;

  // Field positions
  localparam int ROT_COUNT_LSB  = 0;
  localparam int ROT_FUNC_LSB   = 3;
  localparam int MODE_WM_LSB    = 0;
  localparam int MODE_READ_TYPE = 3;
  localparam int MODE_ODD_EVEN  = 4;
  localparam int MODE_SHIFT_FMT = 5;
  localparam int MODE_256       = 6;
  localparam int CSEL_HI_LSB    = 2;

  // Reset values
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [3:0] RST_INDEX = 4'h0;
  localparam logic [7:0] RST_BYTE  = 8'h00;

  // Odd/even write enables
  localparam logic [3:0] EN_ALL  = 4'hF;
  localparam logic [3:0] EN_EVEN = 4'h5;
  localparam logic [3:0] EN_ODD  = 4'hA;

  typedef enum logic [1:0] {
    WM_SET_RESET = 2'h0,
    WM_LATCH     = 2'h1,
    WM_HOST_FILL = 2'h2,
    WM_MASKED_SR = 2'h3
  } vgd_wmode_t;

  typedef enum logic [1:0] {
    FN_PASS = 2'h0,
    FN_AND  = 2'h1,
    FN_OR   = 2'h2,
    FN_XOR  = 2'h3
  } vgd_func_t;

  typedef struct packed {
    logic [3:0]  en;
    logic [31:0] data;
  } vgd_map_wr_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       isData;
    logic [7:0] wdata;
  } vgd_io_req_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addrLow;
    logic [7:0] wdata;
  } vgd_mem_req_t;

endpackage

/* File: vgd_alu.sv */
`timescale 1ns/1ps
module vgd_alu
  import vgd_pkg::*;
(
  // Operands
  input  wire logic [7:0] src,
  input  wire logic [7:0] latch,
  input  wire vgd_func_t  func,
  input  wire logic [7:0] mask,
  // Result
  output logic      [7:0] result
);

  logic [7:0] combined;

  always_comb begin
    case (func)
      FN_AND:  combined = src & latch;
      FN_OR:   combined = src | latch;
      FN_XOR:  combined = src ^ latch;
      default: combined = src;
    endcase
    // Masked positions keep what the latch holds
    result = (combined & mask) | (latch & ~mask);
  end

endmodule // vgd_alu

/* File: vgd_shift_load.sv */
`timescale 1ns/1ps
module vgd_shift_load
  import vgd_pkg::*;
(
  // Map bytes and format
  input  wire logic [31:0]     mapData,
  input  wire logic            mode256,
  input  wire logic            cgaFormat,
  // Parallel load values, one byte per shift register
  output logic      [3:0][7:0] loadVal
);

  logic [3:0][7:0] m;

  always_comb begin
    m = mapData;
    loadVal = m;
    if (mode256) begin
      // High nibble of each pixel byte leaves first
      for (int b = 0; b < 4; b++) begin
        for (int p = 0; p < 4; p++) begin
          loadVal[b][7 - 2*p] = m[p][4 + b];
          loadVal[b][6 - 2*p] = m[p][b];
        end
      end
    end else if (cgaFormat) begin
      for (int k = 0; k < 4; k++) begin
        loadVal[0][7 - k] = m[0][6 - 2*k];
        loadVal[0][3 - k] = m[2][6 - 2*k];
        loadVal[1][7 - k] = m[0][7 - 2*k];
        loadVal[1][3 - k] = m[2][7 - 2*k];
        loadVal[2][7 - k] = m[1][6 - 2*k];
        loadVal[2][3 - k] = m[3][6 - 2*k];
        loadVal[3][7 - k] = m[1][7 - 2*k];
        loadVal[3][3 - k] = m[3][7 - 2*k];
      end
    end
  end

endmodule // vgd_shift_load

/* File: vgd_datapath.sv */
`timescale 1ns/1ps
module vgd_datapath
  import vgd_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Index and data register ports
  input  wire vgd_io_req_t  ioReq,
  output logic      [7:0]   ioRdData,
  // Host memory cycles
  input  wire vgd_mem_req_t memReq,
  input  wire logic [31:0]  mapRdData,
  output logic      [7:0]   memRdData,
  output vgd_map_wr_t       mapWr,
  // Sequencer and attribute settings
  input  wire logic         seqChain4,
  input  wire logic [3:0]   attrColorSel,
  // Video path
  input  wire logic         shiftLoad,
  input  wire logic [31:0]  shiftMapData,
  input  wire logic [5:0]   paletteOut,
  output logic      [3:0]   pixelNibble,
  output logic      [7:0]   videoOut
);

  typedef struct packed {
    logic [3:0]                 index;
    logic [NUM_REGS-1:0][7:0]   regs;
    logic [31:0]                latches;
    logic [7:0]                 ioRd;
    logic [7:0]                 memRd;
    vgd_map_wr_t                mapWr;
    logic [3:0][7:0]            shifter;
    logic [3:0]                 pixel;
    logic [3:0]                 hiNibble;
    logic                       secondDot;
    logic [7:0]                 video;
  } vgd_state_t;

  vgd_state_t s_q;
  vgd_state_t s_d;

  function automatic logic [7:0] rotr8(input logic [7:0] v,
                                       input logic [2:0] n);
    logic [15:0] w;
    w = {v, v} >> n;
    return w[7:0];
  endfunction

  function automatic logic [7:0] colorMatch(input logic [31:0] maps,
                                            input logic [3:0]  color);
    logic [7:0] r;
    r = '1;
    for (int i = 0; i < 4; i++) begin
      r = r & ~(maps[8*i +: 8] ^ {8{color[i]}});
    end
    return r;
  endfunction

  function automatic logic [7:0] regMask(input logic [3:0] idx);
    if (idx == IDX_ROTATE_FUNC) begin
      return MASK_ROTATE;
    end else if (idx == IDX_READ_PLANE) begin
      return MASK_READ_PLANE;
    end else if (idx == IDX_MODE_CTRL) begin
      return MASK_MODE_CTRL;
    end else if (idx == IDX_BIT_MASK) begin
      return MASK_FULL;
    end else begin
      return MASK_NIBBLE;
    end
  endfunction

  // Register fields
  logic [3:0] setReset;
  logic [3:0] srEnable;
  logic [3:0] compareColor;
  logic [2:0] rotCount;
  vgd_func_t  func;
  logic [1:0] planeSel;
  vgd_wmode_t wmode;
  logic       readType;
  logic       oddEven;
  logic       cgaFormat;
  logic       mode256;
  logic [7:0] bitMask;

  assign setReset     = s_q.regs[IDX_SET_RESET][3:0];
  assign srEnable     = s_q.regs[IDX_SR_ENABLE][3:0];
  assign compareColor = s_q.regs[IDX_COMPARE][3:0];
  assign rotCount     = s_q.regs[IDX_ROTATE_FUNC][ROT_COUNT_LSB +: 3];
  assign func         = vgd_func_t'(s_q.regs[IDX_ROTATE_FUNC][ROT_FUNC_LSB +: 2]);
  assign planeSel     = s_q.regs[IDX_READ_PLANE][1:0];
  assign wmode        = vgd_wmode_t'(s_q.regs[IDX_MODE_CTRL][MODE_WM_LSB +: 2]);
  assign readType     = s_q.regs[IDX_MODE_CTRL][MODE_READ_TYPE];
  assign oddEven      = s_q.regs[IDX_MODE_CTRL][MODE_ODD_EVEN];
  assign cgaFormat    = s_q.regs[IDX_MODE_CTRL][MODE_SHIFT_FMT];
  assign mode256      = s_q.regs[IDX_MODE_CTRL][MODE_256];
  assign bitMask      = s_q.regs[IDX_BIT_MASK];

  // Write datapath, one ALU per map
  logic [7:0]      rotated;
  logic [3:0][7:0] aluSrc;
  logic [3:0][7:0] aluOut;
  logic [7:0]      aluMask;

  assign rotated = rotr8(memReq.wdata, rotCount);

  always_comb begin
    aluMask = bitMask;
    for (int i = 0; i < 4; i++) begin
      case (wmode)
        WM_SET_RESET: begin
          aluSrc[i] = srEnable[i] ? {8{setReset[i]}}
                                  : rotated;
        end
        WM_HOST_FILL: begin
          aluSrc[i] = {8{memReq.wdata[i]}};
        end
        WM_MASKED_SR: begin
          aluSrc[i] = {8{setReset[i]}};
        end
        default: begin
          aluSrc[i] = s_q.latches[8*i +: 8];
        end
      endcase
    end
    if (wmode == WM_MASKED_SR) begin
      aluMask = rotated & bitMask;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : gMapAlu
    vgd_alu uAlu (
      .src    (aluSrc[g]),
      .latch  (s_q.latches[8*g +: 8]),
      .func   (func),
      .mask   (aluMask),
      .result (aluOut[g])
    );
  end

  logic [3:0][7:0] loadVal;

  vgd_shift_load uLoad (
    .mapData   (shiftMapData),
    .mode256   (mode256),
    .cgaFormat (cgaFormat),
    .loadVal   (loadVal)
  );

  // Read map choice
  logic [1:0] readMap;

  always_comb begin
    if (seqChain4) begin
      readMap = memReq.addrLow;
    end else if (oddEven) begin
      readMap = {planeSel[1], memReq.addrLow[0]};
    end else begin
      readMap = planeSel;
    end
  end

  always_comb begin
    s_d = s_q;
    // Register ports
    if (ioReq.wr && !ioReq.isData) begin
      s_d.index = ioReq.wdata[3:0];
    end
    if (ioReq.wr && ioReq.isData && s_q.index < NUM_REGS) begin
      s_d.regs[s_q.index] = ioReq.wdata & regMask(s_q.index);
    end
    if (ioReq.rd) begin
      if (!ioReq.isData) begin
        s_d.ioRd = {4'h0, s_q.index};
      end else if (s_q.index < NUM_REGS) begin
        s_d.ioRd = s_q.regs[s_q.index];
      end else begin
        s_d.ioRd = RST_BYTE;
      end
    end
    // Memory reads
    if (memReq.rd) begin
      s_d.latches = mapRdData;
      if (readType) begin
        s_d.memRd = colorMatch(mapRdData, compareColor);
      end else begin
        s_d.memRd = mapRdData[8*readMap +: 8];
      end
    end
    // Memory writes
    s_d.mapWr.en = 4'h0;
    if (memReq.wr) begin
      s_d.mapWr.data = aluOut;
      if (wmode == WM_LATCH) begin
        s_d.mapWr.data = s_q.latches;
      end
      if (oddEven) begin
        s_d.mapWr.en = memReq.addrLow[0] ? EN_ODD : EN_EVEN;
      end else begin
        s_d.mapWr.en = EN_ALL;
      end
    end
    // Video shifters run every clock, MSB first
    if (shiftLoad) begin
      s_d.shifter = loadVal;
    end else begin
      for (int i = 0; i < 4; i++) begin
        s_d.shifter[i] = {s_q.shifter[i][6:0], 1'b0};
      end
    end
    for (int i = 0; i < 4; i++) begin
      s_d.pixel[i] = s_q.shifter[i][7];
    end
    // Two nibbles form one 256-color pixel; a load realigns the pair
    // Loaded MSBs reach pixel one clock after the load, so start on the odd
    // phase; the first nibble out is then taken as the high half
    s_d.secondDot = shiftLoad ? 1'b1 : !s_q.secondDot;
    if (mode256) begin
      if (s_q.secondDot) begin
        s_d.video = {s_q.hiNibble, s_q.pixel};
      end else begin
        s_d.hiNibble = s_q.pixel;
      end
    end else begin
      s_d.video = {attrColorSel[CSEL_HI_LSB +: 2], paletteOut};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.index     <= RST_INDEX;
      s_q.regs      <= '{default: RST_REG};
      s_q.latches   <= '0;
      s_q.ioRd      <= RST_BYTE;
      s_q.memRd     <= RST_BYTE;
      s_q.mapWr     <= '0;
      s_q.shifter   <= '0;
      s_q.pixel     <= 4'h0;
      s_q.hiNibble  <= 4'h0;
      s_q.secondDot <= 1'b0;
      s_q.video     <= RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  assign ioRdData    = s_q.ioRd;
  assign memRdData   = s_q.memRd;
  assign mapWr       = s_q.mapWr;
  assign pixelNibble = s_q.pixel;
  assign videoOut    = s_q.video;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence sIndexWrite;
    ioReq.wr && !ioReq.isData;
  endsequence

  sequence sMemRead;
    memReq.rd;
  endsequence

  sequence sDirectLoad;
    shiftLoad && !mode256 && !cgaFormat;
  endsequence

  chk_index_holds: assert property (sIndexWrite ##1
      (!(ioReq.wr && !ioReq.isData))[*3]
      |-> s_q.index == $past(ioReq.wdata[3:0], 3))
    else $error("index pointer lost its value");

  chk_latch_load: assert property (sMemRead
      |=> s_q.latches == $past(mapRdData))
    else $error("read did not load latches");

  chk_compare_read: assert property (sMemRead ##0 readType
      |=> memRdData == ~(
          ($past(mapRdData[7:0])   ^ {8{$past(compareColor[0])}}) |
          ($past(mapRdData[15:8])  ^ {8{$past(compareColor[1])}}) |
          ($past(mapRdData[23:16]) ^ {8{$past(compareColor[2])}}) |
          ($past(mapRdData[31:24]) ^ {8{$past(compareColor[3])}})))
    else $error("compare read result wrong");

  chk_plain_read: assert property (sMemRead ##0 !readType ##0 !oddEven
      ##0 !seqChain4
      |=> memRdData == $past(mapRdData[8*planeSel +: 8]))
    else $error("map select read wrong");

  chk_latch_copy: assert property (memReq.wr && wmode == WM_LATCH
      && !oddEven
      |=> mapWr.data == $past(s_q.latches) && mapWr.en == EN_ALL)
    else $error("latch copy write wrong");

  chk_mask_keep: assert property (memReq.wr && wmode != WM_LATCH
      |=> ((mapWr.data ^ $past(s_q.latches)) & ~{4{$past(aluMask)}}) == '0)
    else $error("masked bit changed");

  chk_sr_fill: assert property (memReq.wr && wmode == WM_SET_RESET
      && srEnable == EN_ALL && func == FN_PASS && bitMask == MASK_FULL
      |=> mapWr.data == {{8{$past(setReset[3])}}, {8{$past(setReset[2])}},
                         {8{$past(setReset[1])}}, {8{$past(setReset[0])}}})
    else $error("set/reset fill wrong");

  chk_rotate_data: assert property (memReq.wr
      && wmode == WM_SET_RESET && srEnable == 4'h0 && func == FN_PASS
      && bitMask == MASK_FULL
      |=> mapWr.data == {4{8'(($past(memReq.wdata) >> $past(rotCount))
          | ($past(memReq.wdata) << (4'd8 - $past(rotCount))))}})
    else $error("rotated write wrong");

  chk_odd_even_en: assert property (memReq.wr && oddEven
      |=> mapWr.en == ($past(memReq.addrLow[0]) ? EN_ODD : EN_EVEN))
    else $error("odd/even write enable wrong");

  chk_palette_out: assert property (!mode256
      |=> videoOut == {$past(attrColorSel[3:2]), $past(paletteOut)})
    else $error("palette output wrong");

  chk_direct_shift: assert property (sDirectLoad
      |=> ##1 pixelNibble == {$past(shiftMapData[31], 2),
                              $past(shiftMapData[23], 2),
                              $past(shiftMapData[15], 2),
                              $past(shiftMapData[7], 2)})
    else $error("direct shift load wrong");

endmodule // vgd_datapath

/* File: vgd_map_model.sv */
`timescale 1ns/1ps
module vgd_map_model
  import vgd_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Four display maps, one byte location each
  input  wire vgd_map_wr_t mapWr,
  output logic      [31:0] mapRdData
);
  logic [31:0] store = 32'h0;

  // Read data is always present, so it is valid whenever a read is taken
  assign mapRdData = store;

  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (mapWr.en[i]) begin
        store[8*i +: 8] <= mapWr.data[8*i +: 8];
      end
    end
  end

  // Plain always block so the bench may seed contents between cycles
  task preload(input logic [31:0] v);
    store = v;
  endtask
endmodule // vgd_map_model

/* File: vgd_datapath_tb.sv */
`timescale 1ns/1ps
module vgd_datapath_tb
  import vgd_pkg::*;
;
  // Design connections
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  vgd_io_req_t  ioReq = '0;
  logic [7:0]   ioRdData;
  vgd_mem_req_t memReq = '0;
  logic [31:0]  mapRdData;
  logic [7:0]   memRdData;
  vgd_map_wr_t  mapWr;
  logic         seqChain4 = 1'b0;
  logic [3:0]   attrColorSel = 4'hB;
  logic         shiftLoad = 1'b0;
  logic [31:0]  shiftMapData = 32'h81C35AF0;
  logic [5:0]   paletteOut = 6'h2D;
  logic [3:0]   pixelNibble;
  logic [7:0]   videoOut;
  // Bench state
  int           n_fail = 0;
  int           check_count = 0;
  logic [7:0]   v;
  logic [7:0]   s;
  logic [7:0]   m;
  logic [31:0]  mem;
  logic [31:0]  e;
  logic [47:0]  t;
  vgd_map_wr_t  w;
  logic [7:0]   masks [9] = '{8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h03,
                              8'h7B, 8'h0F, 8'h0F, 8'hFF};
  // {mode, rotate, set/reset, enable, bit mask, host byte}
  logic [47:0]  wtab [6] = '{48'h00_03_05_03_FF_A5, 48'h00_0B_0A_00_F0_3C,
                             48'h01_17_00_00_FF_81, 48'h02_10_00_00_0F_06,
                             48'h03_1A_09_00_FE_C3, 48'h00_18_0F_0F_81_00};

  vgd_datapath vgd_datapath_i (
    .clk(clk), .rst_n(rst_n), .ioReq(ioReq), .ioRdData(ioRdData),
    .memReq(memReq), .mapRdData(mapRdData), .memRdData(memRdData),
    .mapWr(mapWr), .seqChain4(seqChain4), .attrColorSel(attrColorSel),
    .shiftLoad(shiftLoad), .shiftMapData(shiftMapData),
    .paletteOut(paletteOut), .pixelNibble(pixelNibble),
    .videoOut(videoOut)
  );

  vgd_map_model vgd_map_model_i (
    .clk(clk), .mapWr(mapWr), .mapRdData(mapRdData)
  );

  always #25 clk = ~clk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task close_out;
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task io_wr(input logic d, input logic [7:0] val);
    @(negedge clk);
    ioReq = '{wr: 1'b1, rd: 1'b0, isData: d, wdata: val};
    @(negedge clk);
    ioReq.wr = 1'b0;
  endtask

  task io_rd(input logic d, output logic [7:0] val);
    @(negedge clk);
    ioReq = '{wr: 1'b0, rd: 1'b1, isData: d, wdata: 8'h00};
    @(negedge clk);
    ioReq.rd = 1'b0;
    val = ioRdData;
  endtask

  task reg_wr(input logic [3:0] idx, input logic [7:0] val);
    io_wr(1'b0, {4'h0, idx});
    io_wr(1'b1, val);
  endtask

  task reg_rd(input logic [3:0] idx, output logic [7:0] val);
    io_wr(1'b0, {4'h0, idx});
    io_rd(1'b1, val);
  endtask

  task mem_rd(input logic [1:0] a, output logic [7:0] val);
    @(negedge clk);
    memReq = '{wr: 1'b0, rd: 1'b1, addrLow: a, wdata: 8'h00};
    @(negedge clk);
    memReq.rd = 1'b0;
    val = memRdData;
  endtask

  task mem_wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk);
    memReq = '{wr: 1'b1, rd: 1'b0, addrLow: a, wdata: d};
    @(negedge clk);
    memReq.wr = 1'b0;
    w = mapWr;
  endtask

  function automatic logic [7:0] rotr(logic [7:0] d, logic [2:0] n);
    return (d >> n) | (d << (4'd8 - n));
  endfunction

  function automatic logic [7:0] alu(logic [7:0] src, logic [7:0] lat,
                                     logic [1:0] f, logic [7:0] bm);
    logic [7:0] r;
    case (f)
      2'h0: r = src;
      2'h1: r = src & lat;
      2'h2: r = src | lat;
      default: r = src ^ lat;
    endcase
    return (r & bm) | (lat & ~bm);
  endfunction

  function automatic logic [7:0] cmp(logic [31:0] mp, logic [3:0] c);
    logic [7:0] r;
    for (int b = 0; b < 8; b++) begin
      r[b] = &(~({mp[24+b], mp[16+b], mp[8+b], mp[b]} ^ c));
    end
    return r;
  endfunction

  // Generous span: the whole sequence needs well under 3000 cycles
  initial begin
    #300us;
    n_fail++;
    close_out();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    // Register table: reset values, implemented bits, unmapped index
    for (int i = 0; i < 9; i++) begin
      reg_rd(i[3:0], v);
      check(v, 8'h00);
      reg_wr(i[3:0], 8'hFF);
      reg_rd(i[3:0], v);
      check(v, masks[i]);
      reg_wr(i[3:0], 8'h00);
    end
    reg_wr(4'h9, 8'hFF);
    reg_rd(4'h9, v);
    check(v, 8'h00);
    io_wr(1'b0, 8'h0C);
    io_rd(1'b0, v);
    check(v, 8'h0C);
    reg_wr(4'h3, 8'h15);
    io_rd(1'b1, v);
    io_rd(1'b1, v);
    check(v, 8'h15);
    // Reads: map select, chain-four, odd/even, compare
    mem = 32'h965AF03C;
    vgd_map_model_i.preload(mem);
    for (int i = 0; i < 4; i++) begin
      reg_wr(IDX_READ_PLANE, i[7:0]);
      mem_rd(2'h0, v);
      check(v, mem[8*i +: 8]);
    end
    seqChain4 = 1'b1;
    reg_wr(IDX_READ_PLANE, 8'h00);
    mem_rd(2'h2, v);
    check(v, mem[23:16]);
    seqChain4 = 1'b0;
    reg_wr(IDX_MODE_CTRL, 8'h10);
    reg_wr(IDX_READ_PLANE, 8'h02);
    mem_rd(2'h1, v);
    check(v, mem[31:24]);
    reg_wr(IDX_READ_PLANE, 8'h01);
    mem_rd(2'h0, v);
    check(v, mem[7:0]);
    reg_wr(IDX_READ_PLANE, 8'h03);
    reg_wr(IDX_MODE_CTRL, 8'h08);
    for (int c = 0; c < 16; c++) begin
      reg_wr(IDX_COMPARE, c[7:0]);
      mem_rd(2'h0, v);
      check(v, cmp(mem, c[3:0]));
    end
    // Writes in every mode and function; latches stay from the last read
    for (int k = 0; k < 6; k++) begin
      t = wtab[k];
      reg_wr(IDX_MODE_CTRL, t[47:40]);
      reg_wr(IDX_ROTATE_FUNC, t[39:32]);
      reg_wr(IDX_SET_RESET, t[31:24]);
      reg_wr(IDX_SR_ENABLE, t[23:16]);
      reg_wr(IDX_BIT_MASK, t[15:8]);
      mem_wr(2'h0, t[7:0]);
      for (int i = 0; i < 4; i++) begin
        m = t[15:8];
        case (t[41:40])
          2'h0: s = t[16+i] ? {8{t[24+i]}} : rotr(t[7:0], t[34:32]);
          2'h2: s = {8{t[i]}};
          default: begin
            s = {8{t[24+i]}};
            m = rotr(t[7:0], t[34:32]) & t[15:8];
          end
        endcase
        e[8*i +: 8] = (t[41:40] == 2'h1) ? mem[8*i +: 8]
                      : alu(s, mem[8*i +: 8], t[36:35], m);
      end
      check(w.en, 4'hF);
      check(w.data, e);
    end
    // Odd/even write steering
    reg_wr(IDX_MODE_CTRL, 8'h10);
    mem_wr(2'h0, 8'h5A);
    check(w.en, EN_EVEN);
    mem_wr(2'h1, 8'h5A);
    check(w.en, EN_ODD);
    reg_wr(IDX_MODE_CTRL, 8'h00);
    // Video: palette and color select, direct shift load MSB first
    repeat (3) @(negedge clk);
    check(videoOut, {attrColorSel[3:2], paletteOut});
    paletteOut = 6'h12;
    attrColorSel = 4'h4;
    repeat (3) @(negedge clk);
    check(videoOut, 8'h52);
    // Loaded MSBs show one clock after the load edge
    shiftLoad = 1'b1;
    @(negedge clk);
    shiftLoad = 1'b0;
    for (int k = 7; k >= 0; k--) begin
      @(negedge clk);
      check(pixelNibble, {shiftMapData[24+k], shiftMapData[16+k],
                          shiftMapData[8+k], shiftMapData[k]});
    end
    // 256-color: each map byte leaves as one whole pixel, map 0 first
    reg_wr(IDX_MODE_CTRL, 8'h40);
    shiftLoad = 1'b1;
    @(negedge clk);
    shiftLoad = 1'b0;
    repeat (2) @(negedge clk);
    for (int p = 0; p < 4; p++) begin
      repeat (2) @(negedge clk);
      check(videoOut, shiftMapData[8*p +: 8]);
    end
    // Split format: odd bits only feed odd shift registers
    shiftMapData = 32'hAAAAAAAA;
    reg_wr(IDX_MODE_CTRL, 8'h20);
    shiftLoad = 1'b1;
    @(negedge clk);
    shiftLoad = 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      check(pixelNibble, 4'hA);
    end
    close_out();
  end
endmodule // vgd_datapath_tb
